/* inc/hcl_pkg.sv */
// Constants and decoded-configuration type for the hub configuration image loader.
package hcl_pkg;

	// ------------------------------------------------------------
	// Image format codes and layout
	// ------------------------------------------------------------
	localparam logic [7:0] FMT_IDS_ONLY   = 8'hd0;
	localparam logic [7:0] FMT_SHORT      = 8'hd2;
	localparam logic [7:0] FMT_EXTENDED   = 8'hd4;
	localparam logic [7:0] BLANK_BYTE     = 8'hff;
	localparam logic [7:0] LEN_IDS_ONLY   = 8'h07;
	localparam logic [7:0] LEN_SHORT      = 8'h0d;
	localparam logic [7:0] LEN_FIXED      = 8'h18;
	localparam int         IMG_BYTES      = 24;
	localparam int         LANG_MAX       = 31;
	localparam logic [7:0] LANG_MAX_COUNT = 8'h1f;

	// Byte positions common to all formats; the filter byte is not in IDs-only images.
	localparam int B_VID_LO   = 1;
	localparam int B_VID_HI   = 2;
	localparam int B_PID_LO   = 3;
	localparam int B_PID_HI   = 4;
	localparam int B_DID      = 6;
	localparam int B_FILTER   = 7;
	// Short format positions.
	localparam int BS_PORTS   = 8;
	localparam int BS_DRAW    = 9;
	localparam int BS_CTRL    = 10;
	localparam int BS_SETTLE  = 11;
	localparam int BS_FLAGS   = 12;
	// Extended format positions.
	localparam int BX_DRAW_FS = 8;
	localparam int BX_DRAW_HS = 9;
	localparam int BX_CB_FS   = 12;
	localparam int BX_CB_HS   = 13;
	localparam int BX_CS_FS   = 14;
	localparam int BX_CS_HS   = 15;
	localparam int BX_SETTLE  = 16;
	localparam int BX_FLAGS   = 17;
	localparam int BX_MODE    = 18;
	localparam int BX_WPROT   = 19;
	localparam int BX_LANGS   = 20;
	localparam int BX_STRINGS = 21;
	localparam int BX_ACTIVE  = 22;
	localparam int BX_REMOVE  = 23;

	// Option flag and mode bit positions.
	localparam int FL_ZERO_DESC = 7;
	localparam int FL_COMBINED  = 6;
	localparam int FL_FS_ONLY   = 5;
	localparam int FL_NO_LEDS   = 4;
	localparam int FL_SHARED    = 2;
	localparam int MD_AMBER     = 7;
	localparam int MD_GREEN     = 6;
	localparam int MD_SELF      = 5;
	localparam int MD_CHOP      = 4;
	localparam int MD_SWITCH    = 3;
	localparam int MD_FAULT_LVL = 2;
	localparam int MD_SENSE_OFF = 1;
	localparam int MD_PER_PORT  = 0;

	// Reset and default values.
	localparam logic [7:0] DEF_FILTER     = 8'h88;
	localparam logic [7:0] DEF_PORTS      = 8'hff;
	localparam logic [3:0] DEF_PORT_MASK  = 4'hf;
	localparam logic [7:0] DEF_DRAW_FS    = 8'h28;
	localparam logic [7:0] DEF_DRAW_HS    = 8'h57;
	localparam logic [7:0] DEF_CTRL_FS    = 8'h50;
	localparam logic [7:0] DEF_CTRL_HS    = 8'hae;
	localparam logic [7:0] DEF_CTRL_S_HS  = 8'h64;
	localparam logic [7:0] DEF_SETTLE     = 8'h32;
	localparam logic [7:0] DEF_FLAGS      = 8'h80;
	localparam logic [7:0] DEF_MODE       = 8'h00;
	localparam logic [7:0] WPROT_CODE     = 8'h42;
	localparam logic [7:0] DESC_TYPE_HUB  = 8'h29;
	localparam logic [7:0] DESC_TYPE_ZERO = 8'h00;
	// Arbitrary neutral identity used when no image supplies one.
	localparam logic [15:0] DEF_VENDOR_ID  = 16'h0001;
	localparam logic [15:0] DEF_PRODUCT_ID = 16'h0001;
	localparam logic [7:0]  DEF_DEVICE_ID  = 8'h01;

	// Decoded configuration.
	typedef struct packed {
		logic [15:0] vendor_id;
		logic [15:0] product_id;
		logic [7:0]  device_id;
		logic [3:0]  live_port_fault_filter_ms;
		logic [3:0]  idle_port_fault_filter_ms;
		logic [3:0]  usable_port_mask;
		logic [3:0]  detachable_port_mask;
		logic [7:0]  draw_fs_2ma;
		logic [7:0]  draw_hs_2ma;
		logic [7:0]  ctrl_bus_fs_ma;
		logic [7:0]  ctrl_bus_hs_ma;
		logic [7:0]  ctrl_self_fs_ma;
		logic [7:0]  ctrl_self_hs_ma;
		logic [7:0]  port_supply_settle_2ms;
		logic        accept_zero_desc_type;
		logic        part_of_combined_unit;
		logic        full_speed_only;
		logic        leds_absent;
		logic        shared_switch_mode;
		logic        amber_led_level;
		logic        green_led_level;
		logic        self_powerable;
		logic        led_chop_enable;
		logic        switch_drive_level;
		logic        fault_input_level;
		logic        fault_sense_off;
		logic        fault_report_per_port;
		logic        write_protect;
		logic [7:0]  language_count;
		logic [7:0]  string_present_bitmap;
		logic        strings_enabled;
		logic        vendor_class;
	} hcl_cfg_type;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_READ   = 4'b0010,
		ST_DECODE = 4'b0100,
		ST_DONE   = 4'b1000
	} hcl_state_type;

endpackage

/* logic/hcl_loader.sv */
// Hub configuration image loader: fetches, decodes and applies the EEPROM image.
`timescale 1ns/10ps
`default_nettype none
module hcl_loader (
	input  wire logic                clk_sys,
	input  wire logic                sys_rst,
	output logic                     ee_rd_req,
	output logic [7:0]               ee_rd_addr,
	input  wire logic [7:0]          ee_rd_data,
	input  wire logic                ee_rd_valid,
	input  wire logic                link_is_hs,
	input  wire logic                self_powered,
	input  wire logic                hub_desc_req,
	input  wire logic [7:0]          hub_desc_type,
	input  wire logic [4:0]          lang_sel,
	output logic                     cfg_done,
	output hcl_pkg::hcl_cfg_type     cfg,
	output logic                     hs_permit,
	output logic                     leds_enable,
	output logic                     fault_sense_enable,
	output logic [7:0]               desc_max_power,
	output logic [7:0]               desc_ctrl_current,
	output logic [7:0]               desc_pwr_on_time,
	output logic [2:0]               desc_port_count,
	output logic [7:0]               desc_removable,
	output logic [15:0]              desc_hub_char,
	output logic                     hub_desc_accept,
	output logic                     hub_desc_stall,
	output logic [15:0]              lang_code
);
	import hcl_pkg::*;

	// ------------------------------------------------------------
	// State and storage
	// ------------------------------------------------------------
	hcl_state_type state_reg;
	hcl_state_type state_next;
	logic [7:0]    img_reg [IMG_BYTES];
	logic [15:0]   lang_reg [LANG_MAX];
	logic [7:0]    idx_reg;
	logic          blank_reg;
	logic          req_reg;
	hcl_cfg_type   cfg_reg;
	hcl_cfg_type   cfg_next;
	logic          done_reg;
	logic          hs_permit_reg;
	logic          leds_enable_reg;
	logic          fault_en_reg;
	logic [7:0]    max_power_reg;
	logic [7:0]    ctrl_current_reg;
	logic [7:0]    pwr_on_reg;
	logic [2:0]    port_count_reg;
	logic [7:0]    removable_reg;
	logic [15:0]   hub_char_reg;
	logic          accept_reg;
	logic          stall_reg;
	logic [15:0]   lang_code_reg;

	// ------------------------------------------------------------
	// Fetch sequencing
	// ------------------------------------------------------------
	logic [7:0] fmt;
	logic       is_ext;
	logic       is_short;
	logic       is_ids;
	logic       lang_ok;
	logic [7:0] end_addr;
	logic       last_byte;
	logic [7:0] lang_off;
	logic [4:0] lang_ent;

	assign fmt       = img_reg[0];
	assign is_ext    = (fmt == FMT_EXTENDED);
	assign is_short  = (fmt == FMT_SHORT);
	assign is_ids    = (fmt == FMT_IDS_ONLY);
	// A count of zero or above the maximum turns all string support off.
	assign lang_ok   = (img_reg[BX_LANGS] != 8'h00) && (img_reg[BX_LANGS] <= LANG_MAX_COUNT);
	// Byte 20 is already stored before the fetch passes byte 23, so the
	// extended length is final by the time it is compared.
	assign end_addr  = is_ids ? LEN_IDS_ONLY :
	                   is_short ? LEN_SHORT :
	                   (is_ext && lang_ok) ? 8'(LEN_FIXED + {img_reg[BX_LANGS][6:0], 1'b0}) :
	                   LEN_FIXED;
	assign last_byte = (idx_reg != 8'h00) && (8'(idx_reg + 8'h01) >= end_addr);
	assign lang_off  = 8'(idx_reg - LEN_FIXED);
	assign lang_ent  = lang_off[5:1];

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:   state_next = ST_READ;
			ST_READ:   state_next = (ee_rd_valid && last_byte) ? ST_DECODE : ST_READ;
			ST_DECODE: state_next = ST_DONE;
			ST_DONE:   state_next = ST_DONE;
			default:   state_next = ST_IDLE;
		endcase
	end

	// Sequencer: the request is held high with a steady address until the
	// memory answers, so a slow serial fetch needs no extra handshake.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
			idx_reg   <= 8'h00;
			blank_reg <= 1'b1;
			req_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			req_reg   <= (state_next == ST_READ) && !(ee_rd_valid && state_reg == ST_READ && last_byte);
			if (state_reg == ST_READ && ee_rd_valid) begin
				idx_reg   <= 8'(idx_reg + 8'h01);
				blank_reg <= blank_reg && (ee_rd_data == BLANK_BYTE);
			end
		end
	end

	// Image capture: the fixed part goes to byte storage, the rest to the
	// language table, two bytes per entry, low byte first.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			for (int i = 0; i < IMG_BYTES; i++) begin
				img_reg[i] <= 8'h00;
			end
			for (int i = 0; i < LANG_MAX; i++) begin
				lang_reg[i] <= 16'h0000;
			end
		end else if (state_reg == ST_READ && ee_rd_valid) begin
			if (idx_reg < LEN_FIXED) begin
				img_reg[idx_reg[4:0]] <= ee_rd_data;
			end else if (lang_off[0] == 1'b0) begin
				lang_reg[lang_ent][7:0] <= ee_rd_data;
			end else begin
				lang_reg[lang_ent][15:8] <= ee_rd_data;
			end
		end
	end

	// ------------------------------------------------------------
	// Image decode
	// ------------------------------------------------------------
	logic [7:0] flags_b;
	logic [7:0] mode_b;
	logic [7:0] ports_b;
	logic       any_hub;

	// Unknown codes other than blank still give a hub with default values.
	assign any_hub = is_ids || is_short || is_ext;
	assign flags_b = is_ext ? img_reg[BX_FLAGS] : is_short ? img_reg[BS_FLAGS] : DEF_FLAGS;
	assign mode_b  = is_ext ? img_reg[BX_MODE] : DEF_MODE;
	assign ports_b = is_short ? img_reg[BS_PORTS] : DEF_PORTS;

	always_comb begin
		cfg_next = '0;
		cfg_next.vendor_id  = any_hub ? {img_reg[B_VID_HI], img_reg[B_VID_LO]} : DEF_VENDOR_ID;
		cfg_next.product_id = any_hub ? {img_reg[B_PID_HI], img_reg[B_PID_LO]} : DEF_PRODUCT_ID;
		cfg_next.device_id  = any_hub ? img_reg[B_DID] : DEF_DEVICE_ID;
		{cfg_next.live_port_fault_filter_ms, cfg_next.idle_port_fault_filter_ms} =
			(is_short || is_ext) ? img_reg[B_FILTER] : DEF_FILTER;
		if (is_ext) begin
			cfg_next.usable_port_mask     = img_reg[BX_ACTIVE][3:0];
			cfg_next.detachable_port_mask = img_reg[BX_REMOVE][3:0];
			cfg_next.draw_fs_2ma          = img_reg[BX_DRAW_FS];
			cfg_next.draw_hs_2ma          = img_reg[BX_DRAW_HS];
			cfg_next.ctrl_bus_fs_ma       = img_reg[BX_CB_FS];
			cfg_next.ctrl_bus_hs_ma       = img_reg[BX_CB_HS];
			cfg_next.ctrl_self_fs_ma      = img_reg[BX_CS_FS];
			cfg_next.ctrl_self_hs_ma      = img_reg[BX_CS_HS];
			cfg_next.port_supply_settle_2ms = img_reg[BX_SETTLE];
		end else if (is_short) begin
			cfg_next.usable_port_mask     = ports_b[7:4];
			cfg_next.detachable_port_mask = ports_b[3:0];
			cfg_next.draw_fs_2ma          = img_reg[BS_DRAW];
			cfg_next.draw_hs_2ma          = img_reg[BS_DRAW];
			cfg_next.ctrl_bus_fs_ma       = img_reg[BS_CTRL];
			cfg_next.ctrl_bus_hs_ma       = img_reg[BS_CTRL];
			cfg_next.ctrl_self_fs_ma      = img_reg[BS_CTRL];
			cfg_next.ctrl_self_hs_ma      = img_reg[BS_CTRL];
			cfg_next.port_supply_settle_2ms = img_reg[BS_SETTLE];
		end else begin
			cfg_next.usable_port_mask     = DEF_PORT_MASK;
			cfg_next.detachable_port_mask = DEF_PORT_MASK;
			cfg_next.draw_fs_2ma          = DEF_DRAW_FS;
			cfg_next.draw_hs_2ma          = DEF_DRAW_HS;
			cfg_next.ctrl_bus_fs_ma       = DEF_CTRL_FS;
			cfg_next.ctrl_bus_hs_ma       = DEF_CTRL_HS;
			cfg_next.ctrl_self_fs_ma      = DEF_CTRL_FS;
			cfg_next.ctrl_self_hs_ma      = DEF_CTRL_S_HS;
			cfg_next.port_supply_settle_2ms = DEF_SETTLE;
		end
		cfg_next.accept_zero_desc_type = flags_b[FL_ZERO_DESC];
		cfg_next.part_of_combined_unit = flags_b[FL_COMBINED];
		cfg_next.full_speed_only       = flags_b[FL_FS_ONLY];
		cfg_next.leds_absent           = flags_b[FL_NO_LEDS];
		cfg_next.shared_switch_mode    = flags_b[FL_SHARED];
		cfg_next.amber_led_level       = mode_b[MD_AMBER];
		cfg_next.green_led_level       = mode_b[MD_GREEN];
		cfg_next.self_powerable        = mode_b[MD_SELF];
		cfg_next.led_chop_enable       = mode_b[MD_CHOP];
		cfg_next.switch_drive_level    = mode_b[MD_SWITCH];
		cfg_next.fault_input_level     = mode_b[MD_FAULT_LVL];
		// Short images carry no mode byte: sensing stays on and per-port reporting follows the switching style.
		cfg_next.fault_sense_off       = is_ext && mode_b[MD_SENSE_OFF];
		cfg_next.fault_report_per_port = is_ext ? mode_b[MD_PER_PORT] : !flags_b[FL_SHARED];
		cfg_next.write_protect         = is_ext && (img_reg[BX_WPROT] == WPROT_CODE);
		cfg_next.language_count        = is_ext ? img_reg[BX_LANGS] : 8'h00;
		cfg_next.string_present_bitmap = is_ext ? img_reg[BX_STRINGS] : 8'h00;
		cfg_next.strings_enabled       = is_ext && lang_ok;
		cfg_next.vendor_class          = blank_reg;
	end

	// ------------------------------------------------------------
	// Descriptor field derivation
	// ------------------------------------------------------------
	logic [2:0]  map_count;
	logic [7:0]  map_removable;
	logic        run_hs;
	logic [15:0] char_next;
	logic        type_ok;

	hcl_port_map #(
		.PORTS(4)
	) u_port_map (
		.usable_port_mask     (cfg_reg.usable_port_mask),
		.detachable_port_mask (cfg_reg.detachable_port_mask),
		.port_count           (map_count),
		.removable_byte       (map_removable)
	);

	// High speed is only ever used when the image allows it.
	assign run_hs = link_is_hs && !cfg_reg.full_speed_only;
	assign char_next = {8'h00,
	                    !cfg_reg.leds_absent,
	                    2'b00,
	                    cfg_reg.fault_sense_off,
	                    !cfg_reg.fault_sense_off && cfg_reg.fault_report_per_port,
	                    cfg_reg.part_of_combined_unit,
	                    1'b0,
	                    !cfg_reg.shared_switch_mode};
	assign type_ok = (hub_desc_type == DESC_TYPE_HUB) ||
	                 (cfg_reg.accept_zero_desc_type && hub_desc_type == DESC_TYPE_ZERO);

	// Decoded configuration is frozen once, when the fetch completes.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cfg_reg  <= '0;
			done_reg <= 1'b0;
		end else if (state_reg == ST_DECODE) begin
			cfg_reg  <= cfg_next;
			done_reg <= 1'b1;
		end
	end

	// Reported values track the live link speed and power source.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			hs_permit_reg    <= 1'b0;
			leds_enable_reg  <= 1'b0;
			fault_en_reg     <= 1'b0;
			max_power_reg    <= 8'h00;
			ctrl_current_reg <= 8'h00;
			pwr_on_reg       <= 8'h00;
			port_count_reg   <= 3'h0;
			removable_reg    <= 8'h00;
			hub_char_reg     <= 16'h0000;
		end else if (done_reg) begin
			hs_permit_reg    <= !cfg_reg.full_speed_only;
			leds_enable_reg  <= !cfg_reg.leds_absent;
			fault_en_reg     <= !cfg_reg.fault_sense_off;
			max_power_reg    <= run_hs ? cfg_reg.draw_hs_2ma : cfg_reg.draw_fs_2ma;
			ctrl_current_reg <= self_powered ?
			                    (run_hs ? cfg_reg.ctrl_self_hs_ma : cfg_reg.ctrl_self_fs_ma) :
			                    (run_hs ? cfg_reg.ctrl_bus_hs_ma : cfg_reg.ctrl_bus_fs_ma);
			pwr_on_reg       <= cfg_reg.port_supply_settle_2ms;
			port_count_reg   <= map_count;
			removable_reg    <= map_removable;
			hub_char_reg     <= char_next;
		end
	end

	// Requests before loading finishes get no answer at all.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			accept_reg    <= 1'b0;
			stall_reg     <= 1'b0;
			lang_code_reg <= 16'h0000;
		end else begin
			accept_reg    <= done_reg && !cfg_reg.vendor_class && hub_desc_req && type_ok;
			stall_reg     <= done_reg && hub_desc_req && (cfg_reg.vendor_class || !type_ok);
			lang_code_reg <= (done_reg && lang_sel != 5'h1f) ? lang_reg[lang_sel] : 16'h0000;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign ee_rd_req          = req_reg;
	assign ee_rd_addr         = idx_reg;
	assign cfg_done           = done_reg;
	assign cfg                = cfg_reg;
	assign hs_permit          = hs_permit_reg;
	assign leds_enable        = leds_enable_reg;
	assign fault_sense_enable = fault_en_reg;
	assign desc_max_power     = max_power_reg;
	assign desc_ctrl_current  = ctrl_current_reg;
	assign desc_pwr_on_time   = pwr_on_reg;
	assign desc_port_count    = port_count_reg;
	assign desc_removable     = removable_reg;
	assign desc_hub_char      = hub_char_reg;
	assign hub_desc_accept    = accept_reg;
	assign hub_desc_stall     = stall_reg;
	assign lang_code          = lang_code_reg;

endmodule
`default_nettype wire

/* logic/hcl_port_map.sv */
// Port counting and logical removable-port map for the hub descriptor.
`timescale 1ns/10ps
`default_nettype none
module hcl_port_map #(
	parameter int PORTS = 4
) (
	input  wire logic [PORTS-1:0] usable_port_mask,
	input  wire logic [PORTS-1:0] detachable_port_mask,
	output logic      [2:0]       port_count,
	output logic      [7:0]       removable_byte
);

	// ------------------------------------------------------------
	// Count usable ports and place removable bits per logical port
	// ------------------------------------------------------------
	// Removable bit i+1 copies detachable bit i of physical port i, for i below
	// port_count only, whichever ports are usable; bit 0 of the byte is reserved.
	always_comb begin
		port_count     = 3'h0;
		removable_byte = 8'h00;
		for (int i = 0; i < PORTS; i++) begin
			port_count = port_count + {2'h0, usable_port_mask[i]};
		end
		for (int i = 0; i < PORTS; i++) begin
			if (i < int'(port_count)) begin
				removable_byte[i+1] = detachable_port_mask[i];
			end
		end
	end

endmodule
`default_nettype wire

/* verif/hcl_ee_model.sv */
// Behavioural serial EEPROM that answers the loader's byte reads.
`timescale 1ns/10ps
`default_nettype none
module hcl_ee_model (
	input  wire logic       clk_sys,
	input  wire logic [7:0] lat,
	input  wire logic       ee_rd_req,
	input  wire logic [7:0] ee_rd_addr,
	output logic      [7:0] ee_rd_data,
	output logic            ee_rd_valid
);
	logic [7:0] mem [0:63];
	logic [7:0] wait_cnt = 8'h00;

	initial ee_rd_data = 8'h00;
	initial ee_rd_valid = 1'b0;

	// Answers after lat idle cycles; between answers the data lines toggle,
	// so a loader that samples outside the valid pulse picks up garbage.
	always @(posedge clk_sys) begin
		if (ee_rd_req && !ee_rd_valid && wait_cnt >= lat) begin
			ee_rd_valid <= 1'b1;
			ee_rd_data <= mem[ee_rd_addr[5:0]];
			wait_cnt <= 8'h00;
		end else begin
			ee_rd_valid <= 1'b0;
			ee_rd_data <= ~ee_rd_data;
			if (ee_rd_req && !ee_rd_valid)
				wait_cnt <= wait_cnt + 8'h01;
		end
	end
endmodule
`default_nettype wire

/* verif/hcl_loader_properties.sv */
// Port assertions for the configuration image loader.
`timescale 1ns/10ps
`default_nettype none
module hcl_loader_properties
	import hcl_pkg::*;
(
	input wire logic         clk_sys,
	input wire logic         sys_rst,
	input wire logic         ee_rd_req,
	input wire logic [7:0]   ee_rd_addr,
	input wire logic         ee_rd_valid,
	input wire logic         hub_desc_req,
	input wire logic [7:0]   hub_desc_type,
	input wire logic         cfg_done,
	input wire hcl_cfg_type  cfg,
	input wire logic         hs_permit,
	input wire logic         leds_enable,
	input wire logic         fault_sense_enable,
	input wire logic [2:0]   desc_port_count,
	input wire logic [15:0]  desc_hub_char,
	input wire logic         hub_desc_accept,
	input wire logic         hub_desc_stall
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	// Loaded hub image; vendor-class mode reports nothing of the hub.
	logic live;
	assign live = cfg_done && !cfg.vendor_class;

	property p_hold; ee_rd_req && !ee_rd_valid |=> ee_rd_req && $stable(ee_rd_addr); endproperty
	a_hold: assert property (p_hold) else $error("read request dropped");
	property p_early; !cfg_done |=> !hub_desc_accept && !hub_desc_stall; endproperty
	a_early: assert property (p_early) else $error("answer before load");
	property p_hub; hub_desc_req && live && hub_desc_type == 8'h29 |=> hub_desc_accept; endproperty
	a_hub: assert property (p_hub) else $error("hub type not accepted");
	property p_zero;
		hub_desc_req && live && hub_desc_type == 8'h00 |=>
			hub_desc_accept == cfg.accept_zero_desc_type && hub_desc_stall != cfg.accept_zero_desc_type;
	endproperty
	a_zero: assert property (p_zero) else $error("zero type answer wrong");
	property p_fs; live |=> hs_permit == !cfg.full_speed_only; endproperty
	a_fs: assert property (p_fs) else $error("speed permit wrong");
	property p_leds; live |=> leds_enable == !cfg.leds_absent && desc_hub_char[7] == !cfg.leds_absent; endproperty
	a_leds: assert property (p_leds) else $error("indicator state wrong");
	property p_char;
		live |=> desc_hub_char[2] == cfg.part_of_combined_unit &&
			desc_hub_char[1:0] == {1'b0, !cfg.shared_switch_mode};
	endproperty
	a_char: assert property (p_char) else $error("characteristics wrong");
	property p_count; live |=> desc_port_count == $countones(cfg.usable_port_mask); endproperty
	a_count: assert property (p_count) else $error("port count wrong");
	property p_sense; live |=> fault_sense_enable == !cfg.fault_sense_off && desc_hub_char[4] == cfg.fault_sense_off; endproperty
	a_sense: assert property (p_sense) else $error("fault sensing wrong");
endmodule
bind hcl_loader hcl_loader_properties hcl_loader_properties_inst (.*);
`default_nettype wire

/* verif/tb_hcl_loader.sv */
// Self-checking bench for the configuration image loader.
`timescale 1ns/10ps
`default_nettype none
module tb_hcl_loader;
	import hcl_pkg::*;
	logic clk_sys = 1'b0, sys_rst = 1'b1, link_is_hs = 1'b1, self_powered = 1'b0, hub_desc_req = 1'b0;
	logic ee_rd_req, ee_rd_valid, cfg_done, hs_permit, leds_enable, fault_sense_enable;
	logic hub_desc_accept, hub_desc_stall;
	logic [7:0] ee_rd_addr, ee_rd_data, ee_lat = 8'h00, hub_desc_type = 8'h00;
	logic [7:0] desc_max_power, desc_ctrl_current, desc_pwr_on_time, desc_removable;
	logic [4:0] lang_sel = 5'h00;
	logic [2:0] desc_port_count;
	logic [15:0] desc_hub_char, lang_code, ans;
	hcl_cfg_type cfg;
	int num_errors = 0, total_checks = 0, cycles = 0;

	hcl_loader hcl_loader_inst (.*);
	hcl_ee_model hcl_ee_model_inst (.clk_sys(clk_sys), .lat(ee_lat), .ee_rd_req(ee_rd_req),
		.ee_rd_addr(ee_rd_addr), .ee_rd_data(ee_rd_data), .ee_rd_valid(ee_rd_valid));

	// Clock of 8 ns and a cycle ceiling that catches a hung load.
	always #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 6000) begin
			num_errors++;
			conclude();
		end
	end

	task automatic conclude();
		if (num_errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One descriptor request pulse; ans holds {accept, stall} one cycle later.
	task automatic ask(input logic [7:0] dtype);
		@(negedge clk_sys);
		hub_desc_req = 1'b1;
		hub_desc_type = dtype;
		@(negedge clk_sys);
		hub_desc_req = 1'b0;
		ans = {14'h0, hub_desc_accept, hub_desc_stall};
	endtask

	// Image bytes are written eight at a time, lowest address in the low byte.
	task automatic put(input int at, input logic [63:0] v);
		for (int i = 0; i < 8; i++)
			hcl_ee_model_inst.mem[at + i] = v[8*i +: 8];
	endtask

	task automatic fill(input logic [7:0] v);
		for (int i = 0; i < 64; i++)
			hcl_ee_model_inst.mem[i] = v;
	endtask

	// Resets the loader, probes it while loading, then waits for completion.
	task automatic restart(input logic [7:0] lat);
		int n;
		ee_lat = lat;
		sys_rst = 1'b1;
		repeat (3) @(negedge clk_sys);
		sys_rst = 1'b0;
		ask(DESC_TYPE_HUB);
		chk(ans, 16'h0000);
		n = 0;
		while (cfg_done !== 1'b1 && n < 800) begin
			@(negedge clk_sys);
			n++;
		end
		chk({15'h0, cfg_done}, 16'h0001);
		repeat (2) @(negedge clk_sys);
	endtask

	task automatic test_blank();
		fill(8'hff);
		restart(8'h00);
		chk({15'h0, cfg.vendor_class}, 16'h0001);
		ask(DESC_TYPE_HUB);
		chk(ans, 16'h0001);
		// An unknown leading code is not blank: a hub with default identity.
		put(0, 64'h5c9a0056781234c1);
		restart(8'h00);
		chk(cfg.vendor_id, DEF_VENDOR_ID);
		chk({cfg.device_id, 7'h0, cfg.vendor_class}, {DEF_DEVICE_ID, 8'h00});
		ask(DESC_TYPE_HUB);
		chk(ans, 16'h0002);
	endtask

	task automatic test_short();
		fill(8'h00);
		put(0, 64'h5c9a0056781234d2);
		put(8, 64'h000000c419403093);
		restart(8'h00);
		chk(cfg.vendor_id, 16'h1234);
		chk(cfg.product_id, 16'h5678);
		chk({cfg.device_id, cfg.live_port_fault_filter_ms, cfg.idle_port_fault_filter_ms}, 16'h9a5c);
		chk({5'h0, desc_port_count, desc_removable}, 16'h0206);
		chk({desc_max_power, desc_ctrl_current}, 16'h3040);
		chk({desc_pwr_on_time, 2'h0, desc_hub_char[7], desc_hub_char[4:0]}, 16'h1924);
		ask(DESC_TYPE_ZERO);
		chk(ans, 16'h0002);
	endtask

	task automatic test_ext();
		fill(8'h00);
		put(0, 64'h5c9a0056781234d4);
		put(8, 64'h3433323100002211);
		put(16, 64'h050d0702425b3045);
		put(24, 64'h0000000004070409);
		self_powered = 1'b1;
		restart(8'h03);
		chk({cfg.draw_fs_2ma, cfg.draw_hs_2ma}, 16'h1122);
		chk({cfg.ctrl_bus_fs_ma, cfg.ctrl_bus_hs_ma}, 16'h3132);
		chk({cfg.ctrl_self_fs_ma, cfg.ctrl_self_hs_ma}, 16'h3334);
		chk({cfg.port_supply_settle_2ms, cfg.language_count}, 16'h4502);
		chk({cfg.string_present_bitmap, 7'h0, cfg.write_protect}, 16'h0701);
		chk({9'h0, cfg.strings_enabled, cfg.amber_led_level, cfg.green_led_level,
			cfg.self_powerable, cfg.led_chop_enable, cfg.switch_drive_level,
			cfg.fault_input_level}, 16'h0056);
		chk({desc_max_power, desc_ctrl_current}, 16'h1133);
		chk({12'h0, hs_permit, leds_enable, fault_sense_enable, cfg.fault_report_per_port}, 16'h0001);
		chk({5'h0, desc_port_count, desc_removable}, 16'h030a);
		chk({10'h0, desc_hub_char[7], desc_hub_char[4:0]}, 16'h0011);
		ask(DESC_TYPE_ZERO);
		chk(ans, 16'h0001);
		lang_sel = 5'h01;
		repeat (2) @(negedge clk_sys);
		chk(lang_code, 16'h0407);
		lang_sel = 5'h00;
		repeat (2) @(negedge clk_sys);
		chk(lang_code, 16'h0409);
	endtask

	task automatic test_ids_only();
		fill(8'h00);
		put(0, 64'h009a0056781234d0);
		self_powered = 1'b0;
		restart(8'h01);
		chk({cfg.device_id, cfg.live_port_fault_filter_ms, cfg.idle_port_fault_filter_ms}, 16'h9a88);
		chk({desc_max_power, desc_ctrl_current}, 16'h57ae);
		chk({5'h0, desc_port_count, desc_removable}, 16'h041e);
		chk({desc_pwr_on_time, 4'h0, desc_hub_char[7], desc_hub_char[2:0]}, 16'h3209);
		chk({14'h0, hs_permit, fault_sense_enable}, 16'h0003);
		ask(DESC_TYPE_ZERO);
		chk(ans, 16'h0002);
		ask(8'h22);
		chk(ans, 16'h0001);
		link_is_hs = 1'b0;
		repeat (2) @(negedge clk_sys);
		chk({desc_max_power, desc_ctrl_current}, 16'h2850);
	endtask

	// Blank image first, then each layout, with a slow EEPROM on the long one (latency 3) and on the IDs-only one (latency 1).
	initial begin
		test_blank();
		test_short();
		test_ext();
		test_ids_only();
		conclude();
	end
endmodule
`default_nettype wire
